/* File: core/irq_defs.svh */
// Offsets, field positions, reset values and sizes of the pending unit
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define SRC_COUNT 39
`define PRIO_W 8
`define ID_W 6
`define ADDR_W 8
`define OFF_PEND_LOW 8'h20
`define OFF_PEND_HIGH 8'h24
`define OFF_THRESHOLD 8'h40
`define OFF_EVT_STATUS 8'h80
`define OFF_EVT_MASK 8'h84
`define SRC_IMPL_MASK 39'h7F_FFFF_500C
`define PEND_HIGH_BASE 32
`define THR_LSB 6
`define THR_W 2
`define THR_RESET 2'h0
`define EVT_DISPATCH 0
`define EVT_BLOCKED 1
`define EVT_W 2
`define EVT_RESET 2'h0
`define READ_ZERO 32'h0000_0000
`endif

/* File: core/irq_pending_status_and_threshold.sv */
// Pending status, priority threshold and dispatch of interrupts
//
// How it works
// - Sources 16-31 appear in low word bits 31:16
// - Status bit is one exactly while pending
// - Bit 14 is source 14, bit 15 zero
// - Bit 12 is source 12, bit 13 zero
// - Bits 3:2 sources 3,2; others read zero
// - High word bits 6:0 sources 32-38
// - Below-threshold priority stays pending, not dispatched
// - Threshold zero disables filtering completely
// - Only threshold bits 7:6 store; rest zero
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_pending_status_and_threshold
  import irq_pkg::*;
#(
  parameter int N = `SRC_COUNT,
  parameter int PW = `PRIO_W,
  parameter int IW = `ID_W,
  parameter int AW = `ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources
  input wire logic [N-1:0] src_set,
  input wire logic [N*PW-1:0] src_priority,
  // Core dispatch handshake
  output logic irq_req,
  output logic [IW-1:0] irq_id,
  input wire logic irq_ack,
  // Event interrupt
  output logic irq
);
  pend_bus_if #(.N(N), .PW(PW), .IW(IW)) pb ();

  logic [`THR_W-1:0] priority_threshold_reg;
  logic [`EVT_W-1:0] evt_status;
  logic [`EVT_W-1:0] evt_mask;
  logic [`EVT_W-1:0] next_evt_status;
  logic [`EVT_W-1:0] next_evt_mask;
  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] evt_clr;
  logic [31:0] next_readdata;
  logic [31:0] pending_status_low_reg;
  logic [31:0] pending_status_high_reg;
  logic req_new;
  logic wr_fire;
  logic blocked_q;
  logic dispatched;
  logic sel_ok;
  logic [PW-1:0] sel_prio;
  ctrl_state_t state;
  ctrl_state_t next_state;

  pend_latch_bank #(.N(N), .IW(IW)) u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .src_set(src_set),
    .pb(pb.bank)
  );

  prio_thresh_filter #(.N(N), .PW(PW), .IW(IW)) u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pb(pb.filter)
  );

  assign pb.prio = src_priority;
  assign pb.thr = priority_threshold_reg;

  // Recheck on the live threshold; a write may land after selection
  assign sel_prio = src_priority[int'(pb.sel_id)*PW +: PW];
  assign sel_ok = (priority_threshold_reg == '0) ||
    (sel_prio >= {priority_threshold_reg, 6'h00});

  // Word views of the pending latches
  assign pending_status_low_reg = {
    pb.pending[31:16],
    1'b0, pb.pending[14],
    1'b0, pb.pending[12],
    8'h00, pb.pending[3:2], 2'h0
  };
  assign pending_status_high_reg = {25'h000_0000,
    pb.pending[`PEND_HIGH_BASE+6:`PEND_HIGH_BASE]};

  // Bus slave: one wait cycle, then a single-cycle answer
  assign req_new = (avs_read || avs_write) && avs_waitrequest;
  assign wr_fire = avs_write && !avs_waitrequest;

  always_comb begin
    next_readdata = `READ_ZERO;
    case (avs_address)
      `OFF_PEND_LOW: next_readdata = pending_status_low_reg;
      `OFF_PEND_HIGH: next_readdata = pending_status_high_reg;
      `OFF_THRESHOLD: next_readdata = {24'h00_0000,
        priority_threshold_reg, 6'h00};
      `OFF_EVT_STATUS: next_readdata = {30'h0, evt_status};
      `OFF_EVT_MASK: next_readdata = {30'h0, evt_mask};
      default: next_readdata = `READ_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (req_new) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= `READ_ZERO;
    end else if (req_new && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

  // Pending words take no writes at all
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      priority_threshold_reg <= `THR_RESET;
    end else if (wr_fire && avs_address == `OFF_THRESHOLD &&
                 avs_byteenable[0]) begin
      priority_threshold_reg <=
        avs_writedata[`THR_LSB+`THR_W-1:`THR_LSB];
    end
  end

  // Event flags, write one to clear; a new event wins
  assign dispatched = (state == ST_REQ) && irq_ack;
  assign evt_set[`EVT_DISPATCH] = dispatched;
  assign evt_set[`EVT_BLOCKED] = pb.blocked && !blocked_q;
  assign evt_clr = (wr_fire && avs_address == `OFF_EVT_STATUS &&
    avs_byteenable[0]) ? avs_writedata[`EVT_W-1:0] : `EVT_RESET;

  always_comb begin
    next_evt_status = (evt_status & ~evt_clr) | evt_set;
    next_evt_mask = evt_mask;
    if (wr_fire && avs_address == `OFF_EVT_MASK && avs_byteenable[0]) begin
      next_evt_mask = avs_writedata[`EVT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_status <= `EVT_RESET;
      evt_mask <= `EVT_RESET;
      blocked_q <= 1'b0;
    end else begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      blocked_q <= pb.blocked;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evt_status & next_evt_mask);
    end
  end

  // Dispatch: offer, wait for ack, clear, let the filter catch up
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (pb.sel_valid && sel_ok) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (irq_ack) begin
          next_state = ST_CLR;
        end
      end
      ST_CLR: next_state = ST_SETTLE;
      ST_SETTLE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Selection is two edges behind a clear, hence the settle step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_id <= '0;
    end else if (state == ST_IDLE && pb.sel_valid && sel_ok) begin
      irq_req <= 1'b1;
      irq_id <= pb.sel_id;
    end else if (dispatched) begin
      irq_req <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pb.clr <= 1'b0;
      pb.clr_id <= '0;
    end else begin
      pb.clr <= dispatched;
      if (dispatched) begin
        pb.clr_id <= irq_id;
      end
    end
  end

  // Helper for the checks below
  logic [PW-1:0] id_prio;
  assign id_prio = src_priority[int'(irq_id)*PW +: PW];

  sequence s_read_answer(logic [AW-1:0] a);
    !avs_waitrequest && avs_read && avs_address == a;
  endsequence

  sequence s_ack;
    irq_req && irq_ack;
  endsequence

  property p_low_map;
    @(posedge clk) disable iff (!rst_n)
    s_read_answer(`OFF_PEND_LOW) |->
      avs_readdata[31:16] == $past(pb.pending[31:16]) &&
      avs_readdata[14] == $past(pb.pending[14]) &&
      avs_readdata[12] == $past(pb.pending[12]) &&
      avs_readdata[3:2] == $past(pb.pending[3:2]);
  endproperty
  a_low_map: assert property (p_low_map)
    else $error("low pending word does not match latches");

  property p_low_rsv;
    @(posedge clk) disable iff (!rst_n)
    s_read_answer(`OFF_PEND_LOW) |->
      !avs_readdata[15] && !avs_readdata[13] &&
      avs_readdata[11:4] == 8'h00 && avs_readdata[1:0] == 2'h0;
  endproperty
  a_low_rsv: assert property (p_low_rsv)
    else $error("reserved low pending bit reads one");

  property p_high_map;
    @(posedge clk) disable iff (!rst_n)
    s_read_answer(`OFF_PEND_HIGH) |->
      avs_readdata[31:7] == 25'h000_0000 &&
      avs_readdata[6:0] == $past(pb.pending[38:32]);
  endproperty
  a_high_map: assert property (p_high_map)
    else $error("high pending word wrong");

  property p_thr_read;
    @(posedge clk) disable iff (!rst_n)
    s_read_answer(`OFF_THRESHOLD) |->
      avs_readdata[31:8] == 24'h00_0000 && avs_readdata[5:0] == 6'h00;
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold fixed bits not zero");

  property p_thr_write;
    @(posedge clk) disable iff (!rst_n)
    (wr_fire && avs_address == `OFF_THRESHOLD && avs_byteenable[0]) |=>
      priority_threshold_reg == $past(avs_writedata[7:6]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write not stored");

  property p_dispatch_ok;
    @(posedge clk) disable iff (!rst_n)
    $rose(irq_req) |->
      $past(pb.thr) == '0 || id_prio >= {$past(pb.thr), 6'h00};
  endproperty
  a_dispatch_ok: assert property (p_dispatch_ok)
    else $error("below-threshold interrupt dispatched");

  property p_fall_on_clear;
    @(posedge clk) disable iff (!rst_n)
    (pb.pending != '0 && $past(!pb.clr)) |->
      (pb.pending & $past(pb.pending)) == $past(pb.pending);
  endproperty
  a_fall_on_clear: assert property (p_fall_on_clear)
    else $error("pending bit dropped without dispatch");

  property p_ack_clear;
    @(posedge clk) disable iff (!rst_n)
    s_ack |=> (pb.clr && pb.clr_id == $past(irq_id) && !irq_req)
      ##1 (state == ST_SETTLE) ##1 (state == ST_IDLE);
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("ack did not clear the dispatched source");

  property p_bus_answer;
    @(posedge clk) disable iff (!rst_n)
    req_new |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> irq == |(evt_status & evt_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with flags");

  // Offer and its number stand until the core takes them
  property p_req_stands;
    @(posedge clk) disable iff (!rst_n)
    (irq_req && !irq_ack) |=> irq_req && $stable(irq_id);
  endproperty
  a_req_stands: assert property (p_req_stands)
    else $error("offer dropped before acknowledge");

  property p_blocked_event;
    @(posedge clk) disable iff (!rst_n)
    $rose(pb.blocked) |=> evt_status[`EVT_BLOCKED];
  endproperty
  a_blocked_event: assert property (p_blocked_event)
    else $error("newly blocked source did not raise its flag");

  property p_thr_gate;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && pb.sel_valid && !sel_ok) |=> !irq_req;
  endproperty
  a_thr_gate: assert property (p_thr_gate)
    else $error("stale selection offered below threshold");

  property p_wait_idle;
    @(posedge clk) disable iff (!rst_n)
    (!avs_read && !avs_write && avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("bus answered without a request");
endmodule

/* File: core/irq_pkg.sv */
// Types shared by the pending unit
package irq_pkg;
`include "irq_defs.svh"
  typedef logic [`SRC_COUNT-1:0] src_vec_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_CLR = 4'h4,
    ST_SETTLE = 4'h8
  } ctrl_state_t;
endpackage

/* File: core/pend_bus_if.sv */
// Internal bundle between latch bank, filter and control
`timescale 1ns/1ps
`include "irq_defs.svh"
interface pend_bus_if #(
  parameter int N = `SRC_COUNT,
  parameter int PW = `PRIO_W,
  parameter int IW = `ID_W
);
  logic [N-1:0] pending;
  logic clr;
  logic [IW-1:0] clr_id;
  logic [N*PW-1:0] prio;
  logic [`THR_W-1:0] thr;
  logic sel_valid;
  logic [IW-1:0] sel_id;
  logic blocked;
  modport bank (output pending, input clr, input clr_id);
  modport filter (input pending, input prio, input thr,
    output sel_valid, output sel_id, output blocked);
  modport ctrl (input pending, input sel_valid, input sel_id,
    input blocked, output clr, output clr_id, output prio, output thr);
endinterface

/* File: core/pend_latch_bank.sv */
// Per-source pending latches
`timescale 1ns/1ps
`include "irq_defs.svh"
module pend_latch_bank
  import irq_pkg::*;
#(
  parameter int N = `SRC_COUNT,
  parameter int IW = `ID_W,
  parameter logic [N-1:0] IMPL = `SRC_IMPL_MASK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Source events
  input wire logic [N-1:0] src_set,
  // Bundle
  pend_bus_if.bank pb
);
  genvar i;
  for (i = 0; i < N; i++) begin : g_src
    localparam logic [IW-1:0] MY_ID = IW'(i);
    logic pend_q;
    // Set beats clear so an event in the clear cycle after the ack survives
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pend_q <= 1'b0;
      end else if (src_set[i] && IMPL[i]) begin
        pend_q <= 1'b1;
      end else if (pb.clr && pb.clr_id == MY_ID) begin
        pend_q <= 1'b0;
      end
    end
    // One flop per bit, so no bit of the vector has two writers
    assign pb.pending[i] = pend_q;
    property p_set_holds;
      @(posedge clk) disable iff (!rst_n)
      (src_set[i] && IMPL[i]) |=> pb.pending[i];
    endproperty
    a_set_holds: assert property (p_set_holds)
      else $error("pending bit missed its event");
    property p_unimpl_zero;
      @(posedge clk) disable iff (!rst_n)
      !IMPL[i] |-> !pb.pending[i];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented source shows pending");
  end
endmodule

/* File: core/prio_thresh_filter.sv */
// Threshold filter and lowest-number selection
`timescale 1ns/1ps
`include "irq_defs.svh"
module prio_thresh_filter
  import irq_pkg::*;
#(
  parameter int N = `SRC_COUNT,
  parameter int PW = `PRIO_W,
  parameter int IW = `ID_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bundle
  pend_bus_if.filter pb
);
  logic [N-1:0] elig;
  logic [PW-1:0] thr_full;
  logic next_valid;
  logic [IW-1:0] next_id;
  assign thr_full = {pb.thr, {`THR_LSB{1'b0}}};
  genvar i;
  for (i = 0; i < N; i++) begin : g_elig
    // Zero threshold switches filtering off
    assign elig[i] = pb.pending[i] && (pb.thr == '0 ||
      pb.prio[i*PW +: PW] >= thr_full);
  end
  always_comb begin
    next_valid = 1'b0;
    next_id = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (elig[k]) begin
        next_valid = 1'b1;
        next_id = IW'(k);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pb.sel_valid <= 1'b0;
      pb.sel_id <= '0;
      pb.blocked <= 1'b0;
    end else begin
      pb.sel_valid <= next_valid;
      pb.sel_id <= next_id;
      pb.blocked <= |(pb.pending & ~elig);
    end
  end
  property p_thr_zero;
      @(posedge clk) disable iff (!rst_n)
      (pb.thr == '0 && |pb.pending) |=> pb.sel_valid;
  endproperty
  a_thr_zero: assert property (p_thr_zero)
    else $error("zero threshold blocked a pending source");
endmodule

/* File: verif/core_ack_model.sv */
// Core model that takes offered interrupts and acknowledges them
`timescale 1ns/1ps
`include "irq_defs.svh"
module core_ack_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Dispatch handshake
  input wire logic irq_req,
  input wire logic [`ID_W-1:0] irq_id,
  output logic irq_ack,
  // Stall before acknowledge, in cycles
  input wire logic [3:0] ack_delay
);
  logic [3:0] wait_cnt;
  logic [`ID_W-1:0] taken[$];
  // Ack lasts one cycle, since the offer drops at the ack edge
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
    end else if (irq_req) begin
      if (wait_cnt >= ack_delay) begin
        irq_ack <= 1'b1;
        wait_cnt <= 4'h0;
        taken.push_back(irq_id);
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

/* File: verif/irq_pending_status_and_threshold_tb.sv */
// Self-checking bench of the pending status and threshold block
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_pending_status_and_threshold_tb;
  import irq_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq_req, irq_ack;
  logic irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, ack_delay;
  logic [`SRC_COUNT-1:0] src_set;
  logic [`SRC_COUNT*`PRIO_W-1:0] src_priority;
  logic [`ID_W-1:0] irq_id;
  int n_fail, check_count;

  irq_pending_status_and_threshold u_dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_set(src_set), .src_priority(src_priority), .irq_req(irq_req),
    .irq_id(irq_id), .irq_ack(irq_ack), .irq(irq));
  core_ack_model u_core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
    .irq_id(irq_id), .irq_ack(irq_ack), .ack_delay(ack_delay));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      chk(1'b0, 1'b1, "bus timeout");
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(q, exp, $sformatf("read %h", a));
  endtask

  task automatic pulse(input logic [`SRC_COUNT-1:0] v);
    @(posedge clk);
    src_set <= v;
    @(posedge clk);
    src_set <= '0;
  endtask

  // Waits until the core model has taken n offers in all
  task automatic wait_taken(input int n);
    int k;
    for (k = 0; k < 2000 && u_core.taken.size() < n; k++) @(posedge clk);
    if (k == 2000) begin
      chk(1'b0, 1'b1, "dispatch timeout");
      finish_test();
    end
  endtask

  task automatic t_reset();
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h24, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    $display("Test reset values done");
  endtask

  // Every implemented source pending but blocked, so the status words stay full
  task automatic t_map();
    int i, seen_req;
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h40, 32'h0000_00C0);
    pulse({`SRC_COUNT{1'b1}});
    seen_req = 0;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (irq_req !== 1'b0) seen_req++;
    end
    chk(seen_req, 0, "blocked offer");
    rd_chk(8'h20, 32'hFFFF_500C);
    rd_chk(8'h24, 32'h0000_007F);
    bus(1'b1, 8'h20, 32'h0000_0000, 4'hF);
    bus(1'b1, 8'h24, 32'h0000_0000, 4'hF);
    rd_chk(8'h20, 32'hFFFF_500C);
    rd_chk(8'h24, 32'h0000_007F);
    rd_chk(8'h80, 32'h0000_0002);
    bus(1'b1, 8'h80, 32'h0000_0002, 4'hF);
    $display("Test status map done");
  endtask

  // Threshold zero releases all, lowest number first, slow core
  task automatic t_drain();
    int i, k;
    ack_delay <= 4'h3;
    bus(1'b1, 8'h40, 32'h0000_0000, 4'hF);
    // 27 implemented sources: 2, 3, 12, 14 and 16 to 38
    wait_taken(27);
    k = 0;
    for (i = 0; i < `SRC_COUNT; i++) begin
      if (`SRC_IMPL_MASK >> i & 1) begin
        chk(u_core.taken[k], i, "dispatch order");
        k++;
      end
    end
    // Last clear lands two edges after its acknowledge
    repeat (4) @(posedge clk);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h24, 32'h0000_0000);
    $display("Test drain done");
  endtask

  // Equal priority is serviced, one below stays pending
  task automatic t_equal();
    ack_delay <= 4'h0;
    src_priority[16*8 +: 8] <= 8'h40;
    src_priority[17*8 +: 8] <= 8'h3F;
    bus(1'b1, 8'h40, 32'h0000_0040, 4'hF);
    pulse(39'h00_0003_0000);
    wait_taken(28);
    repeat (10) @(posedge clk);
    chk(u_core.taken[27], 16, "equal priority");
    chk(u_core.taken.size(), 28, "below threshold");
    rd_chk(8'h20, 32'h0002_0000);
    bus(1'b1, 8'h40, 32'h0000_0000, 4'hF);
    wait_taken(29);
    chk(u_core.taken[28], 17, "released source");
    $display("Test threshold edge done");
  endtask

  // Dispatches left bit 0 set, the blocked source in t_equal bit 1
  task automatic t_irq();
    rd_chk(8'h80, 32'h0000_0003);
    chk(irq, 1'b0, "masked irq");
    bus(1'b1, 8'h84, 32'h0000_0001, 4'hF);
    @(posedge clk);
    chk(irq, 1'b1, "unmasked irq");
    bus(1'b1, 8'h80, 32'h0000_0001, 4'hF);
    @(posedge clk);
    chk(irq, 1'b0, "cleared irq");
    rd_chk(8'h80, 32'h0000_0002);
    bus(1'b1, 8'h84, 32'h0000_0002, 4'hF);
    @(posedge clk);
    chk(irq, 1'b1, "blocked event irq");
    bus(1'b1, 8'h80, 32'h0000_0002, 4'hF);
    @(posedge clk);
    chk(irq, 1'b0, "blocked event cleared");
    rd_chk(8'h80, 32'h0000_0000);
    $display("Test event interrupt done");
  endtask

  task automatic t_unmapped();
    rd_chk(8'h44, 32'h0000_0000);
    bus(1'b1, 8'h44, 32'h0000_00C0, 4'hF);
    bus(1'b1, 8'h40, 32'h0000_00C0, 4'hE);
    rd_chk(8'h40, 32'h0000_0000);
    $display("Test unmapped done");
  endtask

  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    src_set = '0;
    src_priority = '0;
    ack_delay = 4'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_map();
    t_drain();
    t_equal();
    t_irq();
    t_unmapped();
    finish_test();
  end
endmodule
